// ---- rtl/pc_card_socket_signal_logic.sv ----
// How it works
// - memory mode reads the width/protect input as the card's write-protect switch.
// - I/O mode uses the width/protect input as the 16-bit I/O width indication.
// - memory mode reads the ready/irq input as card ready or busy.
// - I/O mode treats an active ready/irq input as a card interrupt request.
// - a low wait input holds the card cycle until it is released.
// - card presence comes from both active-low detect inputs being low.
// - low byte enable selects even bytes, high byte enable selects odd bytes.
// - 8-bit cycles use only the low enable; address bit zero picks the byte.
// - card reset output is low normally and high to reset the card.
// - card reset floats unless card seated, powered and interface enabled.
// - warn/speaker/led input: battery warn, card audio, or drive status by mode.
// - dead/change/ring input: battery dead in memory mode, status change in I/O mode.
// - ring enable bit 7 turns the dead/change input into ring indicate for wake.
// - card voltage is decoded from the two voltage sense inputs together.
// - programming rail selects for supply and programming voltage never both high.
// - 3.3-volt and 5-volt supply selects are never active together.
// - misc control bit 4 routes that socket's card audio to the speaker output.
// - extension control bit 2 enables the activity indicator output.
// - disk mode control bit 1 passes drive-status level to the indicator.
// - extension control bit 1 drives the indicator low during card cycles.
// - attribute select follows the space in memory mode, low in I/O, high in disk.
//
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module pc_card_socket_signal_logic #(
  parameter int NSOCK = pcc_sock_pkg::NUM_SOCKETS
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [NSOCK-1:0] write_protect_or_io_width,
  input wire logic [NSOCK-1:0] ready_or_card_irq,
  input wire logic [NSOCK-1:0] card_wait_b,
  input wire logic [2*NSOCK-1:0] card_detect_pair_b,
  input wire logic [NSOCK-1:0] battery_warn_speaker_led,
  input wire logic [NSOCK-1:0] battery_dead_status_change_ring,
  input wire logic [NSOCK-1:0] voltage_sense_1,
  input wire logic [NSOCK-1:0] voltage_sense_2,
  output logic [2*NSOCK-1:0] card_byte_enables_b,
  output logic [NSOCK-1:0] low_address_bit,
  output logic [NSOCK-1:0] attribute_space_select,
  output logic [NSOCK-1:0] card_reset,
  output logic [NSOCK-1:0] card_reset_oe_b,
  output logic [NSOCK-1:0] prog_rail_select_vcc,
  output logic [NSOCK-1:0] prog_rail_select_pgm,
  output logic [NSOCK-1:0] card_supply_low_select_b,
  output logic [NSOCK-1:0] card_supply_high_select_b,
  output logic speaker_output,
  output logic activity_indicator_output,
  output logic ring_indicate_out
);
  import pcc_sock_pkg::*;

  logic [7:0] intGenCtl;
  logic [7:0] miscCtlOne [NSOCK];
  logic [7:0] extCtlOne [NSOCK];
  logic [7:0] diskModeCtl [NSOCK];
  logic [7:0] powerCtl [NSOCK];

  logic dataWrite;
  logic dataRead;
  logic [7:0] dataAddr;
  logic [31:0] next_hrdata;

  logic [NSOCK-1:0] accBusy;
  logic [NSOCK-1:0] accStart;
  logic [NSOCK-1:0] chgClear;
  logic [NSOCK-1:0] spkrTerm;
  logic [NSOCK-1:0] ledTerm;
  logic [NSOCK-1:0] ringTerm;
  logic [15:0] sockStatus [NSOCK];

  // bus slave: writes take the data phase, reads add one wait state
  wire addrPhase = hsel && hready && htrans[1];

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      dataWrite <= 1'b0;
      dataRead <= 1'b0;
      dataAddr <= 8'h00;
    end else if (clk_en) begin
      if (hready) begin
        dataWrite <= addrPhase && hwrite;
        dataRead <= addrPhase && !hwrite;
        dataAddr <= haddr[7:0];
      end else begin
        dataRead <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else if (clk_en) begin
      hresp <= 1'b0;
      if (addrPhase && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (dataRead) begin
        hreadyout <= 1'b1;
        hrdata <= next_hrdata;
      end
    end
  end

  function automatic logic sockHit(input logic [7:0] a, input int s);
    sockHit = (a[7:5] == 3'(s + 1)) && (a[1:0] == 2'h0);
  endfunction

  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (dataAddr == OFS_INT_GEN_CTL) begin
      next_hrdata = {24'h00_0000, intGenCtl};
    end
    for (int s = 0; s < NSOCK; s++) begin
      if (sockHit(dataAddr, s)) begin
        case (dataAddr[4:0])
          OFS_MISC_CTL_ONE: next_hrdata = {24'h00_0000, miscCtlOne[s]};
          OFS_EXT_CTL_ONE: next_hrdata = {24'h00_0000, extCtlOne[s]};
          OFS_DISK_MODE_CTL: next_hrdata = {24'h00_0000, diskModeCtl[s]};
          OFS_POWER_CTL: next_hrdata = {24'h00_0000, powerCtl[s]};
          OFS_ACCESS: next_hrdata = {31'h0000_0000, accBusy[s]};
          OFS_STATUS: next_hrdata = {16'h0000, sockStatus[s]};
          default: next_hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      intGenCtl <= RESET_CTL;
      for (int s = 0; s < NSOCK; s++) begin
        miscCtlOne[s] <= RESET_CTL;
        extCtlOne[s] <= RESET_CTL;
        diskModeCtl[s] <= RESET_CTL;
        powerCtl[s] <= RESET_CTL;
      end
    end else if (clk_en && dataWrite) begin
      if (dataAddr == OFS_INT_GEN_CTL) begin
        intGenCtl <= hwdata[7:0];
      end
      for (int s = 0; s < NSOCK; s++) begin
        if (sockHit(dataAddr, s)) begin
          case (dataAddr[4:0])
            OFS_MISC_CTL_ONE: miscCtlOne[s] <= hwdata[7:0];
            OFS_EXT_CTL_ONE: extCtlOne[s] <= hwdata[7:0];
            OFS_DISK_MODE_CTL: diskModeCtl[s] <= hwdata[7:0];
            OFS_POWER_CTL: powerCtl[s] <= hwdata[7:0];
            default: ;
          endcase
        end
      end
    end
  end

  wire ringEnable = intGenCtl[IGC_RING_BIT];

  for (genvar s = 0; s < NSOCK; s++) begin : g_sock
    if_mode_e mode;
    acc_state_e accState;
    logic [2:0] accCount;
    logic reqAddr0;
    logic reqWide;
    logic reqAttr;
    logic reqAuto;
    logic lastWide;
    logic chgSticky;
    logic present;
    logic powered;
    logic wideNow;
    logic ioWide;
    logic cardIrq;
    logic stsChange;
    logic ringActive;

    always_comb begin
      case (miscCtlOne[s][MISC_MODE_LSB +: 2])
        2'h1: mode = MODE_IO;
        2'h2: mode = MODE_DISK;
        default: mode = MODE_MEMORY;
      endcase
    end

    assign present = !card_detect_pair_b[2*s] && !card_detect_pair_b[2*s+1];
    assign powered = powerCtl[s][PWR_VCC3_BIT] ^ powerCtl[s][PWR_VCC5_BIT];
    assign ioWide = (mode == MODE_IO) && !write_protect_or_io_width[s];
    assign cardIrq = (mode == MODE_IO) && !ready_or_card_irq[s];
    assign ringActive = ringEnable && !battery_dead_status_change_ring[s];
    assign stsChange = (mode == MODE_IO) && !ringEnable && !battery_dead_status_change_ring[s];
    assign wideNow = reqAuto ? ioWide : reqWide;

    always_comb begin
      sockStatus[s] = 16'h0000;
      sockStatus[s][ST_PRESENT] = present;
      sockStatus[s][ST_WRITE_PROT] = (mode == MODE_MEMORY) && write_protect_or_io_width[s];
      sockStatus[s][ST_IO_WIDE] = ioWide;
      sockStatus[s][ST_READY] = (mode == MODE_MEMORY) && ready_or_card_irq[s];
      sockStatus[s][ST_CARD_IRQ] = cardIrq;
      sockStatus[s][ST_BATT_WARN] = (mode == MODE_MEMORY) && !battery_warn_speaker_led[s];
      sockStatus[s][ST_BATT_DEAD] = (mode == MODE_MEMORY) && !ringEnable
        && !battery_dead_status_change_ring[s];
      sockStatus[s][ST_STS_CHANGE] = stsChange;
      sockStatus[s][ST_RING] = ringActive;
      sockStatus[s][ST_DRIVE_LED] = (mode == MODE_DISK) && !battery_warn_speaker_led[s];
      sockStatus[s][ST_VS_LSB +: 2] = {voltage_sense_2[s], voltage_sense_1[s]};
      sockStatus[s][ST_BUSY] = accBusy[s];
      sockStatus[s][ST_LAST_WIDE] = lastWide;
      sockStatus[s][ST_CHG_STICKY] = chgSticky;
    end

    assign accStart[s] = dataWrite && sockHit(dataAddr, s) && (dataAddr[4:0] == OFS_ACCESS);
    assign chgClear[s] = dataWrite && sockHit(dataAddr, s) && (dataAddr[4:0] == OFS_STATUS)
      && hwdata[ST_CHG_STICKY];
    assign accBusy[s] = (accState != ACC_IDLE);
    assign spkrTerm[s] = !(miscCtlOne[s][MISC_SPKR_BIT] && (mode == MODE_IO)
      && !battery_warn_speaker_led[s]);
    assign ledTerm[s] = (diskModeCtl[s][DISK_PASS_BIT] && !battery_warn_speaker_led[s])
      || (extCtlOne[s][EXT_ACTIVITY_BIT] && accBusy[s]);
    assign ringTerm[s] = ringActive;

    // status change latch: a new event wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
      if (!rst_b) begin
        chgSticky <= 1'b0;
      end else if (clk_en) begin
        chgSticky <= stsChange || (chgSticky && !chgClear[s]);
      end
    end

    always_ff @(posedge core_clk) begin
      if (!rst_b) begin
        accState <= ACC_IDLE;
        accCount <= 3'h0;
        reqAddr0 <= 1'b0;
        reqWide <= 1'b0;
        reqAttr <= 1'b0;
        reqAuto <= 1'b0;
        lastWide <= 1'b0;
      end else if (clk_en) begin
        case (accState)
          ACC_IDLE: begin
            if (accStart[s] && present) begin
              reqAddr0 <= hwdata[ACC_ADDR0_BIT];
              reqWide <= hwdata[ACC_WIDE_BIT];
              reqAttr <= hwdata[ACC_ATTR_BIT];
              reqAuto <= hwdata[ACC_AUTO_BIT];
              accCount <= SETUP_CYC;
              accState <= ACC_SETUP;
            end
          end
          ACC_SETUP: begin
            if (accCount <= 3'h1) begin
              lastWide <= wideNow;
              accCount <= CMD_CYC;
              accState <= ACC_CMD;
            end else begin
              accCount <= accCount - 3'h1;
            end
          end
          ACC_CMD: begin
            if (accCount > 3'h1) begin
              accCount <= accCount - 3'h1;
            end else if (card_wait_b[s]) begin
              accCount <= RECOV_CYC;
              accState <= ACC_RECOV;
            end
          end
          ACC_RECOV: begin
            if (accCount <= 3'h1) begin
              accState <= ACC_IDLE;
            end else begin
              accCount <= accCount - 3'h1;
            end
          end
          default: accState <= ACC_IDLE;
        endcase
      end
    end

    // card-side pins
    always_ff @(posedge core_clk) begin
      if (!rst_b) begin
        card_byte_enables_b[2*s +: 2] <= 2'h3;
        low_address_bit[s] <= 1'b0;
        attribute_space_select[s] <= 1'b1;
      end else if (clk_en) begin
        if (accState == ACC_CMD) begin
          if (lastWide && !reqAddr0) begin
            card_byte_enables_b[2*s +: 2] <= 2'h0;
          end else if (lastWide) begin
            card_byte_enables_b[2*s +: 2] <= 2'h1;
          end else begin
            card_byte_enables_b[2*s +: 2] <= 2'h2;
          end
        end else begin
          card_byte_enables_b[2*s +: 2] <= 2'h3;
        end
        low_address_bit[s] <= reqAddr0;
        case (mode)
          MODE_IO: attribute_space_select[s] <= 1'b0;
          MODE_DISK: attribute_space_select[s] <= 1'b1;
          default: attribute_space_select[s] <= !(accBusy[s] && reqAttr);
        endcase
      end
    end

    always_ff @(posedge core_clk) begin
      if (!rst_b) begin
        card_reset[s] <= 1'b0;
        card_reset_oe_b[s] <= 1'b1;
        prog_rail_select_vcc[s] <= 1'b0;
        prog_rail_select_pgm[s] <= 1'b0;
        card_supply_low_select_b[s] <= 1'b1;
        card_supply_high_select_b[s] <= 1'b1;
      end else if (clk_en) begin
        card_reset[s] <= powerCtl[s][PWR_RESET_BIT];
        card_reset_oe_b[s] <= !(present && powered && powerCtl[s][PWR_IF_EN_BIT]);
        prog_rail_select_vcc[s] <= powerCtl[s][PWR_VPP_VCC_BIT] && !powerCtl[s][PWR_PROG_RAIL_SELECT_PGM_BIT];
        prog_rail_select_pgm[s] <= powerCtl[s][PWR_PROG_RAIL_SELECT_PGM_BIT] && !powerCtl[s][PWR_VPP_VCC_BIT];
        card_supply_low_select_b[s] <= !(powerCtl[s][PWR_VCC3_BIT] && !powerCtl[s][PWR_VCC5_BIT]);
        card_supply_high_select_b[s] <= !(powerCtl[s][PWR_VCC5_BIT] && !powerCtl[s][PWR_VCC3_BIT]);
      end
    end
  end

  // shared outputs
  logic indicatorEnable;

  always_comb begin
    indicatorEnable = 1'b0;
    for (int s = 0; s < NSOCK; s++) begin
      indicatorEnable = indicatorEnable || extCtlOne[s][EXT_IND_EN_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      speaker_output <= 1'b1;
      activity_indicator_output <= 1'b1;
      ring_indicate_out <= 1'b0;
    end else if (clk_en) begin
      speaker_output <= &spkrTerm;
      activity_indicator_output <= !(indicatorEnable && (|ledTerm));
      ring_indicate_out <= |ringTerm;
    end
  end

endmodule // pc_card_socket_signal_logic

`default_nettype wire

// ---- rtl/pcc_sock_pkg.sv ----
`default_nettype none
package pcc_sock_pkg;

  localparam int NUM_SOCKETS = 2;

  // byte addresses on the register bus
  localparam logic [7:0] OFS_INT_GEN_CTL = 8'h00;
  localparam logic [7:0] OFS_SOCK_BASE = 8'h20;
  localparam logic [7:0] OFS_SOCK_STRIDE = 8'h20;
  localparam logic [4:0] OFS_MISC_CTL_ONE = 5'h00;
  localparam logic [4:0] OFS_EXT_CTL_ONE = 5'h04;
  localparam logic [4:0] OFS_DISK_MODE_CTL = 5'h08;
  localparam logic [4:0] OFS_POWER_CTL = 5'h0C;
  localparam logic [4:0] OFS_ACCESS = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;

  localparam logic [7:0] RESET_CTL = 8'h00;

  // field positions
  localparam int IGC_RING_BIT = 7;
  localparam int MISC_SPKR_BIT = 4;
  localparam int MISC_MODE_LSB = 0;
  localparam int EXT_ACTIVITY_BIT = 1;
  localparam int EXT_IND_EN_BIT = 2;
  localparam int DISK_PASS_BIT = 1;
  localparam int PWR_VCC3_BIT = 0;
  localparam int PWR_VCC5_BIT = 1;
  localparam int PWR_VPP_VCC_BIT = 2;
  localparam int PWR_PROG_RAIL_SELECT_PGM_BIT = 3;
  localparam int PWR_IF_EN_BIT = 4;
  localparam int PWR_RESET_BIT = 5;
  localparam int ACC_ADDR0_BIT = 0;
  localparam int ACC_WIDE_BIT = 1;
  localparam int ACC_ATTR_BIT = 2;
  localparam int ACC_AUTO_BIT = 3;
  localparam int ST_PRESENT = 0;
  localparam int ST_WRITE_PROT = 1;
  localparam int ST_IO_WIDE = 2;
  localparam int ST_READY = 3;
  localparam int ST_CARD_IRQ = 4;
  localparam int ST_BATT_WARN = 5;
  localparam int ST_BATT_DEAD = 6;
  localparam int ST_STS_CHANGE = 7;
  localparam int ST_RING = 8;
  localparam int ST_DRIVE_LED = 9;
  localparam int ST_VS_LSB = 10;
  localparam int ST_BUSY = 12;
  localparam int ST_LAST_WIDE = 13;
  localparam int ST_CHG_STICKY = 14;

  typedef enum logic [1:0] {
    MODE_MEMORY = 2'h0,
    MODE_IO = 2'h1,
    MODE_DISK = 2'h2
  } if_mode_e;

  typedef enum logic [3:0] {
    ACC_IDLE = 4'h1,
    ACC_SETUP = 4'h2,
    ACC_CMD = 4'h4,
    ACC_RECOV = 4'h8
  } acc_state_e;

  // card cycle timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SETUP_NS = 60;
  localparam int CMD_NS = 160;
  localparam int RECOV_NS = 80;
  localparam logic [2:0] SETUP_CYC = 3'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] CMD_CYC = 3'((CMD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] RECOV_CYC = 3'((RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

`default_nettype wire

// ---- testbench/pcc_sock_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcc_sock_asserts #(
  parameter int NSOCK = 2
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [NSOCK-1:0] card_wait_b,
  input wire logic [2*NSOCK-1:0] card_detect_pair_b,
  input wire logic [NSOCK-1:0] battery_warn_speaker_led,
  input wire logic [NSOCK-1:0] battery_dead_status_change_ring,
  input wire logic [2*NSOCK-1:0] card_byte_enables_b,
  input wire logic [NSOCK-1:0] low_address_bit,
  input wire logic [NSOCK-1:0] card_reset_oe_b,
  input wire logic [NSOCK-1:0] prog_rail_select_vcc,
  input wire logic [NSOCK-1:0] prog_rail_select_pgm,
  input wire logic [NSOCK-1:0] card_supply_low_select_b,
  input wire logic [NSOCK-1:0] card_supply_high_select_b,
  input wire logic speaker_output,
  input wire logic ring_indicate_out
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  logic act;
  // socket 0 command phase seen at the pins
  assign act = card_byte_enables_b[1:0] != 2'b11;
  sequence s_cmd_hold;
    act [*4];
  endsequence
  sequence s_audio_quiet;
    (&battery_warn_speaker_led) [*3];
  endsequence
  sequence s_ring_quiet;
    (&battery_dead_status_change_ring) [*3];
  endsequence
  sequence s_s1_empty;
    (card_detect_pair_b[3:2] == 2'b11) [*3];
  endsequence
  property p_rail_excl;
    !(|(prog_rail_select_vcc & prog_rail_select_pgm));
  endproperty
  a_rail_excl: assert property (p_rail_excl) else $error("both vpp selects high");
  property p_supply_excl;
    &(card_supply_low_select_b | card_supply_high_select_b);
  endproperty
  a_supply_excl: assert property (p_supply_excl) else $error("both supply selects low");
  property p_reset_gate;
    !card_reset_oe_b[0] |-> card_detect_pair_b[1:0] == 2'b00
      && card_supply_low_select_b[0] != card_supply_high_select_b[0];
  endproperty
  a_reset_gate: assert property (p_reset_gate) else $error("card reset driven without card or power");
  property p_even;
    card_byte_enables_b[1:0] == 2'b00 |-> !low_address_bit[0];
  endproperty
  a_even: assert property (p_even) else $error("word access on odd address");
  property p_odd;
    card_byte_enables_b[1:0] == 2'b01 |-> low_address_bit[0];
  endproperty
  a_odd: assert property (p_odd) else $error("odd enable alone on even address");
  property p_cmd_min;
    $rose(act) |-> s_cmd_hold;
  endproperty
  a_cmd_min: assert property (p_cmd_min) else $error("command phase too short");
  property p_wait_hold;
    act && !card_wait_b[0] |=> act;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("cycle ended during wait");
  property p_audio_idle;
    s_audio_quiet |=> speaker_output;
  endproperty
  a_audio_idle: assert property (p_audio_idle) else $error("speaker low without audio");
  property p_ring_idle;
    s_ring_quiet |=> !ring_indicate_out;
  endproperty
  a_ring_idle: assert property (p_ring_idle) else $error("ring out without ring input");
  property p_s1_idle;
    s_s1_empty |=> card_byte_enables_b[3:2] == 2'b11;
  endproperty
  a_s1_idle: assert property (p_s1_idle) else $error("empty socket enables active");
endmodule // pcc_sock_asserts
`default_nettype wire

// ---- testbench/card_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module card_model (
  input wire logic core_clk,
  input wire logic [1:0] inserted,
  input wire logic [3:0] card_byte_enables_b,
  input wire logic [3:0] stall,
  output logic [3:0] card_detect_pair_b,
  output logic [1:0] card_wait_b,
  output logic [1:0] voltage_sense_1,
  output logic [1:0] voltage_sense_2
);
  logic [3:0] cnt [2] = '{4'h0, 4'h0};
  logic [1:0] seen = 2'h0;
  // empty socket floats to the pull-ups
  assign card_detect_pair_b = {{2{~inserted[1]}}, {2{~inserted[0]}}};
  assign voltage_sense_1 = ~inserted;
  assign voltage_sense_2 = {~inserted[1], 1'b1};
  assign card_wait_b = ~inserted | {cnt[1] == 4'h0, cnt[0] == 4'h0};
  // hold wait low for stall cycles once, from the start of each command phase
  always_ff @(posedge core_clk) begin
    for (int s = 0; s < 2; s++) begin
      seen[s] <= card_byte_enables_b[2*s+:2] != 2'b11;
      if (card_byte_enables_b[2*s+:2] != 2'b11 && !seen[s])
        cnt[s] <= stall;
      else if (cnt[s] != 4'h0)
        cnt[s] <= cnt[s] - 4'h1;
    end
  end
endmodule // card_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pcc_sock_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire logic hready;
  logic hreadyout, hresp, spkr, led, ring;
  logic [31:0] hrdata, v;
  logic [1:0] wpIn = 2'b11, rdyIn = 2'b11, warnIn = 2'b11, deadIn = 2'b11, inserted = 2'b00;
  logic [1:0] waitB, senseOne, senseTwo, addrBit, attrSel, cardReset, oeB, railVcc, railPgm, supLowB, supHighB;
  logic [3:0] cdB, beB, stall = 4'h6;
  logic [3:0] accTab [4] = '{4'h0, 4'h1, 4'h6, 4'h3};
  logic [1:0] beTab [4] = '{2'b10, 2'b10, 2'b00, 2'b01};
  int error_cnt = 0, compares = 0, n;
  always #20 core_clk = ~core_clk;
  assign hready = hreadyout;
  pc_card_socket_signal_logic i_pc_card_socket_signal_logic (.core_clk(core_clk), .rst_b(rst_b),
    .clk_en(1'b1), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .write_protect_or_io_width(wpIn), .ready_or_card_irq(rdyIn), .card_wait_b(waitB),
    .card_detect_pair_b(cdB), .battery_warn_speaker_led(warnIn), .battery_dead_status_change_ring(deadIn),
    .voltage_sense_1(senseOne), .voltage_sense_2(senseTwo), .card_byte_enables_b(beB), .low_address_bit(addrBit),
    .attribute_space_select(attrSel), .card_reset(cardReset), .card_reset_oe_b(oeB),
    .prog_rail_select_vcc(railVcc), .prog_rail_select_pgm(railPgm), .card_supply_low_select_b(supLowB),
    .card_supply_high_select_b(supHighB), .speaker_output(spkr), .activity_indicator_output(led),
    .ring_indicate_out(ring));
  card_model i_card_model (.core_clk(core_clk), .inserted(inserted), .card_byte_enables_b(beB),
    .stall(stall), .card_detect_pair_b(cdB), .card_wait_b(waitB), .voltage_sense_1(senseOne),
    .voltage_sense_2(senseTwo));
  function automatic logic [7:0] sa(input int s, input logic [4:0] o);
    return OFS_SOCK_BASE + 8'(s) * OFS_SOCK_STRIDE + {3'h0, o};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ready is registered, so its level before the edge is what the edge samples
  task automatic hs;
    do @(negedge core_clk); while (hreadyout !== 1'b1);
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    haddr <= {24'h0, a};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    hs();
    htrans <= 2'h0;
    hwdata <= d;
    hs();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    haddr <= {24'h0, a};
    hwrite <= 1'b0;
    htrans <= 2'h2;
    hs();
    htrans <= 2'h0;
    hs();
    d = hrdata;
  endtask
  task automatic st;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic setin(input logic [1:0] w, input logic [1:0] r, input logic [1:0] b2, input logic [1:0] b1);
    @(posedge core_clk);
    wpIn <= w;
    rdyIn <= r;
    warnIn <= b2;
    deadIn <= b1;
    st();
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    st();
    chk("be", beB, 4'hF);
    chk("oe", oeB, 2'b11);
    chk("rst", cardReset, 2'b00);
    chk("sup", {supLowB, supHighB}, 4'hF);
    chk("led", led, 1'b1);
    rd(8'hF0, v);
    chk("unmapped", v, 32'h0);
    chk("hresp", hresp, 1'b0);
    inserted <= 2'b01;
    setin(2'b11, 2'b11, 2'b10, 2'b10);
    rd(sa(0, OFS_STATUS), v);
    chk("pres0", v[ST_PRESENT], 1'b1);
    chk("vs0", v[ST_VS_LSB+:2], 2'b10);
    chk("wp", v[ST_WRITE_PROT], 1'b1);
    chk("rdy", v[ST_READY], 1'b1);
    chk("warn", v[ST_BATT_WARN], 1'b1);
    chk("dead", v[ST_BATT_DEAD], 1'b1);
    chk("regmem", attrSel[0], 1'b1);
    rd(sa(1, OFS_STATUS), v);
    chk("pres1", v[ST_PRESENT], 1'b0);
    chk("sense1", v[ST_VS_LSB+:2], 2'b11);
    wr(sa(0, OFS_MISC_CTL_ONE), 32'h11);
    rd(sa(0, OFS_MISC_CTL_ONE), v);
    chk("misc", v, 32'h11);
    setin(2'b10, 2'b10, 2'b10, 2'b10);
    rd(sa(0, OFS_STATUS), v);
    chk("iow", v[ST_IO_WIDE], 1'b1);
    chk("irq", v[ST_CARD_IRQ], 1'b1);
    chk("chg", v[ST_STS_CHANGE], 1'b1);
    chk("regio", attrSel[0], 1'b0);
    chk("spk", spkr, 1'b0);
    wr(sa(0, OFS_MISC_CTL_ONE), 32'h01);
    st();
    chk("spkoff", spkr, 1'b1);
    wr(OFS_INT_GEN_CTL, 32'h80);
    st();
    chk("ring", ring, 1'b1);
    rd(sa(0, OFS_STATUS), v);
    chk("ringst", v[ST_RING], 1'b1);
    wr(OFS_INT_GEN_CTL, 32'h00);
    st();
    chk("ringoff", ring, 1'b0);
    wr(sa(0, OFS_MISC_CTL_ONE), 32'h02);
    wr(sa(0, OFS_DISK_MODE_CTL), 32'h02);
    setin(2'b11, 2'b11, 2'b10, 2'b11);
    rd(sa(0, OFS_STATUS), v);
    chk("drv", v[ST_DRIVE_LED], 1'b1);
    chk("regdisk", attrSel[0], 1'b1);
    chk("ledoff", led, 1'b1);
    wr(sa(0, OFS_EXT_CTL_ONE), 32'h04);
    st();
    chk("ledpass", led, 1'b0);
    setin(2'b11, 2'b11, 2'b11, 2'b11);
    chk("ledhi", led, 1'b1);
    wr(sa(0, OFS_POWER_CTL), 32'h0F);
    st();
    chk("sup2", {supLowB[0], supHighB[0], railVcc[0], railPgm[0]}, 4'hC);
    wr(sa(0, OFS_POWER_CTL), 32'h35);
    wr(sa(1, OFS_POWER_CTL), 32'h35);
    st();
    chk("pw3", {supLowB[0], supHighB[0], railVcc[0], railPgm[0]}, 4'h6);
    chk("rston", {cardReset[0], oeB}, 3'b110);
    wr(sa(0, OFS_POWER_CTL), 32'h1A);
    st();
    chk("pw5", {supLowB[0], supHighB[0], railVcc[0], railPgm[0]}, 4'h9);
    chk("run", {cardReset[0], oeB[0]}, 2'b00);
    wr(sa(0, OFS_POWER_CTL), 32'h0A);
    st();
    chk("float", oeB[0], 1'b1);
    wr(sa(0, OFS_MISC_CTL_ONE), 32'h00);
    wr(sa(0, OFS_DISK_MODE_CTL), 32'h00);
    wr(sa(0, OFS_EXT_CTL_ONE), 32'h06);
    for (int i = 0; i < 4; i++) begin
      wr(sa(0, OFS_ACCESS), {28'h0, accTab[i]});
      do @(negedge core_clk); while (beB[1:0] === 2'b11);
      chk("ce", beB[1:0], beTab[i]);
      chk("abit", addrBit[0], i[0]);
      chk("reg", attrSel[0], !accTab[i][2]);
      n = 0;
      while (beB[1:0] !== 2'b11) begin
        n++;
        if (n == 3)
          chk("ledact", led, 1'b0);
        @(negedge core_clk);
      end
      chk("cmdlen", n >= 7, 1'b1);
      do rd(sa(0, OFS_ACCESS), v); while (v[0] === 1'b1);
    end
    // auto width in I/O mode follows the card's width input
    wr(sa(0, OFS_MISC_CTL_ONE), 32'h01);
    setin(2'b10, 2'b11, 2'b11, 2'b11);
    wr(sa(0, OFS_ACCESS), 32'h8);
    do @(negedge core_clk); while (beB[1:0] === 2'b11);
    chk("auto", beB[1:0], 2'b00);
    do rd(sa(0, OFS_ACCESS), v); while (v[0] === 1'b1);
    wr(sa(0, OFS_STATUS), 32'h4000);
    rd(sa(0, OFS_STATUS), v);
    chk("unstick", v[ST_CHG_STICKY], 1'b0);
    setin(2'b10, 2'b11, 2'b11, 2'b10);
    setin(2'b10, 2'b11, 2'b11, 2'b11);
    rd(sa(0, OFS_STATUS), v);
    chk("stick", v[ST_CHG_STICKY], 1'b1);
    wr(sa(1, OFS_ACCESS), 32'h0);
    rd(sa(1, OFS_STATUS), v);
    chk("nocard", v[ST_BUSY], 1'b0);
    wrap_up();
  end
endmodule // tb_top
bind pc_card_socket_signal_logic pcc_sock_asserts #(.NSOCK(NSOCK)) i_pcc_sock_asserts (
  .core_clk(core_clk), .rst_b(rst_b), .card_wait_b(card_wait_b), .card_detect_pair_b(card_detect_pair_b),
  .battery_warn_speaker_led(battery_warn_speaker_led),
  .battery_dead_status_change_ring(battery_dead_status_change_ring),
  .card_byte_enables_b(card_byte_enables_b), .low_address_bit(low_address_bit),
  .card_reset_oe_b(card_reset_oe_b), .prog_rail_select_vcc(prog_rail_select_vcc),
  .prog_rail_select_pgm(prog_rail_select_pgm), .card_supply_low_select_b(card_supply_low_select_b),
  .card_supply_high_select_b(card_supply_high_select_b), .speaker_output(speaker_output),
  .ring_indicate_out(ring_indicate_out));
`default_nettype wire
